/* File: logic/eepr_pkg.sv */
// Shared constants and types for the two-wire serial memory and its bus master.
// Assumes a 20 MHz system clock on both ends.
package eepr_pkg;
	localparam int CLK_NS = 50;
	localparam logic [3:0] SEL_PATTERN = 4'ha;
	localparam int PAGE_BITS = 5;
	localparam int PAGE_BYTES = 32;
	localparam int ADDR_W_SMALL = 12;
	localparam int ADDR_W_LARGE = 13;
	localparam int SYNC_LEN = 3;
	localparam int WORD_BITS = 8;
	localparam int RECOVER_CLOCKS = 9;
	// Self-timed write, longest allowed time rounds down
	localparam int TWR_MAX_NS = 5000000;
	localparam int TWR_CYC = TWR_MAX_NS / CLK_NS;
	// Master clock quarter phase, least time rounds up
	localparam int QUARTER_NS = 625;
	localparam int QUARTER_CYC = (QUARTER_NS + CLK_NS - 1) / CLK_NS;
	typedef enum logic [1:0] {EEPR_OP_WRITE, EEPR_OP_READ, EEPR_OP_RECOVER} eepr_op_t;
endpackage

/* File: logic/eepr_if.sv */
// Two-wire link between the memory and its master.
// Assumes the testbench instantiates it; the wired-AND level of the data line is resolved here.
`timescale 1ns/1ps
interface eepr_if;
	logic host_scl;
	logic host_sda_o;
	logic host_sda_oe_n;
	logic dev_sda_o;
	logic dev_sda_oe_n;
	wire scl;
	wire sda;
	// Open-drain pull-up on data: line low only while a driver enables a low; the master drives the clock
	assign scl = host_scl;
	assign sda = ~((~host_sda_oe_n & ~host_sda_o) | (~dev_sda_oe_n & ~dev_sda_o));
	modport dev (input scl, input sda, output dev_sda_o, output dev_sda_oe_n);
	modport host (input sda, output host_scl, output host_sda_o, output host_sda_oe_n);
endinterface

/* File: logic/eepr_dev.sv */
// Two-wire serial memory slave with 32-byte pages and a self-timed write cycle.
// Assumes the link pins arrive asynchronously and the master makes the serial clock.
`timescale 1ns/1ps
module eepr_dev import eepr_pkg::*;
#(
	parameter int ADDR_W = ADDR_W_LARGE,
	parameter int TWR_CYCLES = TWR_CYC
)
(
	input wire logic mclk,
	input wire logic nrst,
	input wire logic chip_select_bit_2,
	input wire logic chip_select_bit_1,
	input wire logic chip_select_bit_0,
	input wire logic write_protect,
	eepr_if.dev bus,
	output logic standby,
	output logic write_busy
);
	localparam int TW = $clog2(TWR_CYCLES + 1) + 1;
	localparam int DEPTH = 1 << ADDR_W;

	typedef enum {D_IDLE, D_RX, D_ACK, D_TX, D_TXACK, D_WRCYC} eepr_dstate_t;
	typedef enum {R_SEL, R_AHI, R_ALO, R_DATA} eepr_role_t;

	////////////////////////////////////////////////////////////////////////////
	// Pin synchroniser: {scl, sda, wp, cs2, cs1, cs0}
	logic [5:0] s1_q, s2_q, s3_q, f_q, fp_q;
	logic scl_rise, scl_fall, start_ev, stop_ev;
	logic [2:0] cs_pins;

	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			s1_q <= 6'h30;
			s2_q <= 6'h30;
			s3_q <= 6'h30;
			f_q <= 6'h30;
			fp_q <= 6'h30;
		end
		else
		begin
			s1_q <= {bus.scl, bus.sda, write_protect, chip_select_bit_2, chip_select_bit_1, chip_select_bit_0};
			s2_q <= s1_q;
			s3_q <= s2_q;
			// Change counts only once stages two and three agree
			f_q <= (s2_q & ~(s2_q ^ s3_q)) | (f_q & (s2_q ^ s3_q));
			fp_q <= f_q;
		end
	end

	assign scl_rise = f_q[5] & ~fp_q[5];
	assign scl_fall = ~f_q[5] & fp_q[5];
	// Data edges while clock high are conditions, not data
	assign start_ev = f_q[5] & fp_q[5] & fp_q[4] & ~f_q[4];
	assign stop_ev = f_q[5] & fp_q[5] & ~fp_q[4] & f_q[4];
	// Floating straps are pulled low at the pad, so open pins read as zero
	assign cs_pins = f_q[2:0];

	////////////////////////////////////////////////////////////////////////////
	// Storage and page buffer
	logic [7:0] mem [DEPTH];
	logic [7:0] pbuf [PAGE_BYTES];
	logic [PAGE_BYTES-1:0] valid_q;
	logic [ADDR_W-1:0] addr_q;
	logic [TW-1:0] twr_q;
	logic [7:0] rd_byte;

	function automatic logic [ADDR_W-1:0] page_inc(input logic [ADDR_W-1:0] a);
		page_inc = {a[ADDR_W-1:PAGE_BITS], PAGE_BITS'(a[PAGE_BITS-1:0] + 1'b1)};
	endfunction

	assign rd_byte = mem[addr_q];

	////////////////////////////////////////////////////////////////////////////
	// Link state machine
	eepr_dstate_t st_q;
	eepr_role_t role_q;
	logic [7:0] sh_q;
	logic [3:0] bit_q;
	logic rw_q, mack_q, oe_n_q, standby_q, busy_q;

	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			st_q <= D_IDLE;
			role_q <= R_SEL;
			sh_q <= 8'h00;
			bit_q <= 4'h0;
			rw_q <= 1'b0;
			mack_q <= 1'b0;
			oe_n_q <= 1'b1;
			standby_q <= 1'b1;
			busy_q <= 1'b0;
			addr_q <= '0;
			valid_q <= '0;
		end
		else if (st_q == D_WRCYC)
		begin
			// Inputs ignored until programming ends
			if (twr_q == TW'(TWR_CYCLES - 1))
			begin
				st_q <= D_IDLE;
				busy_q <= 1'b0;
				standby_q <= 1'b1;
				valid_q <= '0;
			end
		end
		else if (start_ev)
		begin
			// The transfer in progress is dropped; buffered page bytes stay valid until the next address high byte or the end of the write cycle that a stop starts
			st_q <= D_RX;
			role_q <= R_SEL;
			bit_q <= 4'h0;
			oe_n_q <= 1'b1;
			standby_q <= 1'b0;
		end
		else if (stop_ev)
		begin
			oe_n_q <= 1'b1;
			if (|valid_q)
			begin
				st_q <= D_WRCYC;
				busy_q <= 1'b1;
			end
			else
			begin
				st_q <= D_IDLE;
				standby_q <= 1'b1;
			end
		end
		else
		begin
			case (st_q)
				D_RX:
				begin
					if (scl_rise)
					begin
						sh_q <= {sh_q[6:0], f_q[4]};
						bit_q <= bit_q + 4'h1;
					end
					else if (scl_fall && bit_q == 4'(WORD_BITS))
					begin
						st_q <= D_ACK;
						oe_n_q <= 1'b0;
						case (role_q)
							R_SEL:
							begin
								// Mismatch means another device was addressed
								if (sh_q[7:4] == SEL_PATTERN && sh_q[3:1] == cs_pins)
								begin
									rw_q <= sh_q[0];
									role_q <= R_AHI;
								end
								else
								begin
									st_q <= D_IDLE;
									oe_n_q <= 1'b1;
									standby_q <= 1'b1;
								end
							end
							R_AHI:
							begin
								addr_q[ADDR_W-1:8] <= sh_q[ADDR_W-9:0];
								valid_q <= '0;
								role_q <= R_ALO;
							end
							R_ALO:
							begin
								addr_q[7:0] <= sh_q;
								role_q <= R_DATA;
							end
							default:
							begin
								pbuf[addr_q[PAGE_BITS-1:0]] <= sh_q;
								if (!f_q[3])
									valid_q[addr_q[PAGE_BITS-1:0]] <= 1'b1;
								addr_q <= page_inc(addr_q);
							end
						endcase
					end
				end
				D_ACK:
				begin
					if (scl_fall)
					begin
						bit_q <= 4'h0;
						if (rw_q)
						begin
							sh_q <= rd_byte;
							oe_n_q <= rd_byte[7];
							addr_q <= addr_q + 1'b1;
							st_q <= D_TX;
						end
						else
						begin
							oe_n_q <= 1'b1;
							st_q <= D_RX;
						end
					end
				end
				D_TX:
				begin
					if (scl_rise)
						bit_q <= bit_q + 4'h1;
					else if (scl_fall)
					begin
						// New bit only after the clock has fallen
						if (bit_q == 4'(WORD_BITS))
						begin
							oe_n_q <= 1'b1;
							st_q <= D_TXACK;
						end
						else
						begin
							oe_n_q <= sh_q[6];
							sh_q <= {sh_q[6:0], 1'b0};
						end
					end
				end
				D_TXACK:
				begin
					if (scl_rise)
						mack_q <= ~f_q[4];
					else if (scl_fall)
					begin
						bit_q <= 4'h0;
						if (mack_q)
						begin
							sh_q <= rd_byte;
							oe_n_q <= rd_byte[7];
							addr_q <= addr_q + 1'b1;
							st_q <= D_TX;
						end
						else
							st_q <= D_IDLE;
					end
				end
				default:
				begin
					st_q <= D_IDLE;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Write cycle timer and page commit, one byte per clock at its start
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
			twr_q <= '0;
		else if (st_q != D_WRCYC)
			twr_q <= '0;
		else
			twr_q <= twr_q + 1'b1;
	end

	always_ff @(posedge mclk)
	begin
		if (st_q == D_WRCYC && twr_q < TW'(PAGE_BYTES) && valid_q[twr_q[PAGE_BITS-1:0]])
			mem[{addr_q[ADDR_W-1:PAGE_BITS], twr_q[PAGE_BITS-1:0]}] <= pbuf[twr_q[PAGE_BITS-1:0]];
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs
	logic sda_o_q;

	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
			sda_o_q <= 1'b0;
		else
			sda_o_q <= 1'b0; // Never drives high
	end

	assign bus.dev_sda_o = sda_o_q;
	assign bus.dev_sda_oe_n = oe_n_q;
	assign standby = standby_q;
	assign write_busy = busy_q;
endmodule

/* File: logic/eepr_host.sv */
// Bus master for the two-wire memory: byte write, random read, protocol recovery.
// Assumes one request at a time; it makes the serial clock from its own clock.
`timescale 1ns/1ps
module eepr_host import eepr_pkg::*;
#(
	parameter int QCYC = QUARTER_CYC
)
(
	input wire logic mclk,
	input wire logic nrst,
	input wire logic req,
	input wire eepr_op_t op,
	input wire logic [2:0] sel_bits,
	input wire logic [15:0] addr,
	input wire logic [7:0] wdata,
	eepr_if.host bus,
	output logic busy,
	output logic done,
	output logic nack,
	output logic [7:0] rdata
);
	typedef enum {K_START, K_TX, K_RX, K_STOP, K_END} eepr_kind_t;
	localparam int QW = $clog2(QCYC + 1);

	function automatic eepr_kind_t step_kind(input eepr_op_t o, input logic [3:0] i);
		step_kind = K_END;
		case (o)
			EEPR_OP_WRITE: step_kind = (i == 4'h0) ? K_START : (i < 4'h5) ? K_TX : (i == 4'h5) ? K_STOP : K_END;
			EEPR_OP_READ:
				step_kind = (i == 4'h0 || i == 4'h4) ? K_START : (i == 4'h6) ? K_RX : (i == 4'h7) ? K_STOP :
					(i > 4'h7) ? K_END : K_TX;
			// Start, nine released clocks, start, stop
			default: step_kind = (i == 4'h0 || i == 4'h2) ? K_START : (i == 4'h1) ? K_RX : (i == 4'h3) ? K_STOP : K_END;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Data line synchroniser
	logic s1_q, s2_q, s3_q, f_q;

	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			s1_q <= 1'b1;
			s2_q <= 1'b1;
			s3_q <= 1'b1;
			f_q <= 1'b1;
		end
		else
		begin
			s1_q <= bus.sda;
			s2_q <= s1_q;
			s3_q <= s2_q;
			if (s2_q == s3_q)
				f_q <= s2_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Step sequencer: each bit or condition takes four quarters
	eepr_op_t op_q;
	logic [2:0] sel_q;
	logic [15:0] addr_q;
	logic [7:0] wdata_q, tx_byte, rx_q;
	logic [3:0] step_q, bit_q;
	logic [1:0] qi_q;
	logic [QW-1:0] qc_q;
	logic run_q, scl_q, sda_q, done_q, nack_q, zero_q;
	eepr_kind_t kind;

	assign kind = step_kind(op_q, step_q);

	always_comb
	begin
		case (step_q)
			4'h1: tx_byte = {SEL_PATTERN, sel_q, 1'b0};
			4'h2: tx_byte = addr_q[15:8];
			4'h3: tx_byte = addr_q[7:0];
			4'h4: tx_byte = wdata_q;
			default: tx_byte = {SEL_PATTERN, sel_q, 1'b1};
		endcase
	end

	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			op_q <= EEPR_OP_WRITE;
			sel_q <= 3'h0;
			addr_q <= 16'h0000;
			wdata_q <= 8'h00;
			rx_q <= 8'h00;
			step_q <= 4'h0;
			bit_q <= 4'h0;
			qi_q <= 2'h0;
			qc_q <= '0;
			run_q <= 1'b0;
			scl_q <= 1'b1;
			sda_q <= 1'b1;
			done_q <= 1'b0;
			nack_q <= 1'b0;
		end
		else
		begin
			done_q <= 1'b0;
			if (!run_q)
			begin
				if (req)
				begin
					op_q <= op;
					sel_q <= sel_bits; // Pinless parts need zero here
					addr_q <= addr;
					wdata_q <= wdata;
					step_q <= 4'h0;
					bit_q <= 4'h0;
					qi_q <= 2'h0;
					qc_q <= '0;
					nack_q <= 1'b0;
					run_q <= 1'b1;
				end
			end
			else if (kind == K_END)
			begin
				run_q <= 1'b0;
				done_q <= 1'b1;
			end
			else if (qc_q != QW'(QCYC - 1))
				qc_q <= qc_q + 1'b1;
			else
			begin
				qc_q <= '0;
				qi_q <= qi_q + 2'h1;
				case (qi_q)
					2'h0: scl_q <= 1'b0;
					// Data bits move only with the clock low; start and stop move it in quarter 3 with the clock high
					2'h1: sda_q <= (kind == K_START) ? 1'b1 : (kind == K_STOP) ? 1'b0 :
						(kind == K_TX && bit_q < 4'(WORD_BITS)) ? tx_byte[3'(7 - bit_q)] : 1'b1;
					2'h2: scl_q <= 1'b1;
					default:
					begin
						if (kind == K_START || kind == K_STOP)
						begin
							sda_q <= (kind == K_STOP);
							step_q <= step_q + 4'h1;
							bit_q <= 4'h0;
						end
						else if (bit_q < 4'(RECOVER_CLOCKS - 1))
						begin
							if (kind == K_RX)
								rx_q <= {rx_q[6:0], f_q};
							bit_q <= bit_q + 4'h1;
						end
						else
						begin
							bit_q <= 4'h0;
							if (kind == K_TX && f_q)
							begin
								// No acknowledge: busy or absent device, end with stop
								nack_q <= 1'b1;
								step_q <= (op_q == EEPR_OP_READ) ? 4'h7 : 4'h5;
							end
							else
								step_q <= step_q + 4'h1;
						end
					end
				endcase
			end
		end
	end

	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
			zero_q <= 1'b0;
		else
			zero_q <= 1'b0;
	end

	assign bus.host_scl = scl_q;
	assign bus.host_sda_o = zero_q;
	assign bus.host_sda_oe_n = sda_q;
	assign busy = run_q;
	assign done = done_q;
	assign nack = nack_q;
	assign rdata = rx_q;
endmodule

/* File: tb/eepr_asserts.sv */
// Link checks between the memory and its master.
// Assumes the bench feeds it the interface signals, system clock and reset.
`timescale 1ns/1ps
module eepr_asserts
(
	input wire logic mclk,
	input wire logic nrst,
	input wire logic scl,
	input wire logic sda,
	input wire logic host_sda_o,
	input wire logic host_sda_oe_n,
	input wire logic dev_sda_o,
	input wire logic dev_sda_oe_n
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!nrst);
	////////////////////////////////////////////////////////////////
	sequence start_ev;
		scl && $fell(sda);
	endsequence
	sequence stop_ev;
		scl && $rose(sda);
	endsequence
	////////////////////////////////////////////////////////////////
	a_dev_no_high: assert property (dev_sda_o == 1'b0)
		else $error("device drives data high");
	a_host_no_high: assert property (host_sda_o == 1'b0)
		else $error("master drives data high");
	a_dev_scl_low: assert property ($changed(dev_sda_oe_n) |-> !scl)
		else $error("device data changed with clock high");
	a_dev_bit_hold: assert property ($fell(dev_sda_oe_n) |-> !dev_sda_oe_n [*8])
		else $error("device low bit too short");
	a_dev_bit_ready: assert property ($fell(dev_sda_oe_n) |-> ##[1:24] $rose(scl))
		else $error("device low bit not sampled");
	a_dev_release: assert property ($fell(dev_sda_oe_n) |-> ##[1:300] $rose(dev_sda_oe_n))
		else $error("device holds data low too long");
	// Clock must stay high a while so the far end sees the condition
	a_start_hold: assert property (start_ev |-> scl [*4])
		else $error("clock fell right after start");
	a_stop_hold: assert property (stop_ev |-> (scl && sda) [*4])
		else $error("bus not idle after stop");
endmodule

/* File: tb/eepr_tb.sv */
// Bench joining the memory and its master over the link interface.
// Assumes package, interface and both ends are compiled first.
`timescale 1ns/1ps
module eepr_tb import eepr_pkg::*;
;
	// Long enough that a poll right after a write still finds it busy
	localparam int TWR = 1000;
	typedef struct packed {eepr_op_t op; logic [2:0] sel; logic wp; logic [15:0] a; logic [7:0] wd;
		logic nk; logic [7:0] rd;} eepr_row_t;
	eepr_row_t rows [10] = '{
		'{EEPR_OP_WRITE, 3'h5, 1'b0, 16'h0123, 8'ha5, 1'b0, 8'h00},
		'{EEPR_OP_READ, 3'h5, 1'b0, 16'h0123, 8'h00, 1'b0, 8'ha5},
		'{EEPR_OP_WRITE, 3'h3, 1'b0, 16'h0123, 8'h5a, 1'b1, 8'h00},
		'{EEPR_OP_WRITE, 3'h5, 1'b1, 16'h0123, 8'h00, 1'b0, 8'h00},
		'{EEPR_OP_READ, 3'h5, 1'b1, 16'he123, 8'h00, 1'b0, 8'ha5},
		'{EEPR_OP_WRITE, 3'h5, 1'b0, 16'h1fff, 8'h3c, 1'b0, 8'h00},
		'{EEPR_OP_READ, 3'h5, 1'b0, 16'h1fff, 8'h00, 1'b0, 8'h3c},
		'{EEPR_OP_READ, 3'h1, 1'b0, 16'h1fff, 8'h00, 1'b1, 8'h00},
		'{EEPR_OP_RECOVER, 3'h5, 1'b0, 16'h0000, 8'h00, 1'b0, 8'h00},
		'{EEPR_OP_READ, 3'h5, 1'b0, 16'h0123, 8'h00, 1'b0, 8'ha5}
	};
	logic mclk = 1'b0;
	logic nrst = 1'b0;
	logic req = 1'b0;
	logic wp = 1'b0;
	eepr_op_t op = EEPR_OP_WRITE;
	logic [2:0] sel = 3'h0;
	logic [2:0] cs = 3'h5;
	logic [15:0] addr = 16'h0000;
	logic [7:0] wdata = 8'h00;
	logic standby, write_busy, busy, done, nack;
	logic [7:0] rdata;
	int num_errors = 0;
	int total_checks = 0;
	int cnt;
	////////////////////////////////////////////////////////////////
	eepr_if lnk();
	eepr_dev #(.ADDR_W(ADDR_W_LARGE), .TWR_CYCLES(TWR)) eepr_dev_i (.mclk(mclk), .nrst(nrst),
		.chip_select_bit_2(cs[2]), .chip_select_bit_1(cs[1]), .chip_select_bit_0(cs[0]),
		.write_protect(wp), .bus(lnk.dev), .standby(standby), .write_busy(write_busy));
	eepr_host #(.QCYC(8)) eepr_host_i (.mclk(mclk), .nrst(nrst), .req(req), .op(op), .sel_bits(sel),
		.addr(addr), .wdata(wdata), .bus(lnk.host), .busy(busy), .done(done), .nack(nack), .rdata(rdata));
	eepr_asserts eepr_asserts_i (.mclk(mclk), .nrst(nrst), .scl(lnk.scl), .sda(lnk.sda),
		.host_sda_o(lnk.host_sda_o), .host_sda_oe_n(lnk.host_sda_oe_n),
		.dev_sda_o(lnk.dev_sda_o), .dev_sda_oe_n(lnk.dev_sda_oe_n));
	////////////////////////////////////////////////////////////////
	always #25 mclk = ~mclk;
	task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
		total_checks++;
		if (s !== e)
		begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic run(input eepr_op_t o, input logic [2:0] s, input logic [15:0] a, input logic [7:0] d);
		@(negedge mclk);
		op = o;
		sel = s;
		addr = a;
		wdata = d;
		req = 1'b1;
		@(negedge mclk);
		req = 1'b0;
		for (int i = 0; i < 4000 && done !== 1'b1; i++)
			@(negedge mclk);
		chk("done", done, 16'h1);
	endtask
	task automatic wait_wr();
		// Stop reaches the device through its synchroniser a few clocks after done
		repeat (8) @(negedge mclk);
		cnt = 0;
		while (write_busy === 1'b1 && cnt < 2 * TWR)
		begin
			@(negedge mclk);
			cnt++;
		end
	endtask
	task automatic finish_test();
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	initial
	begin
		#3000000;
		num_errors++;
		finish_test();
	end
	initial
	begin
		repeat (3) @(negedge mclk);
		nrst = 1'b1;
		foreach (rows[i])
		begin
			wp = rows[i].wp;
			run(rows[i].op, rows[i].sel, rows[i].a, rows[i].wd);
			chk("nack", nack, rows[i].nk);
			if (rows[i].op == EEPR_OP_READ && !rows[i].nk)
				chk("rdata", rdata, rows[i].rd);
			wait_wr();
			chk("wr_cycle", cnt > 0, rows[i].op == EEPR_OP_WRITE && !rows[i].nk && !rows[i].wp);
			chk("twr", cnt <= TWR, 16'h1);
			chk("standby", standby, 16'h1);
		end
		// Poll straight after a write must be refused
		run(EEPR_OP_WRITE, 3'h5, 16'h0040, 8'h11);
		run(EEPR_OP_READ, 3'h5, 16'h0040, 8'h00);
		chk("poll_nack", nack, 16'h1);
		wait_wr();
		run(EEPR_OP_READ, 3'h5, 16'h0040, 8'h00);
		chk("poll_data", rdata, 16'h0011);
		// Reset in the middle of a write cycle
		run(EEPR_OP_WRITE, 3'h5, 16'h0041, 8'h22);
		repeat (8) @(negedge mclk);
		chk("wbusy_on", write_busy, 16'h1);
		nrst = 1'b0;
		repeat (3) @(negedge mclk);
		chk("rst_wbusy", write_busy, 16'h0);
		chk("rst_stby", standby, 16'h1);
		chk("rst_sda", lnk.dev_sda_oe_n, 16'h1);
		chk("rst_busy", busy, 16'h0);
		nrst = 1'b1;
		run(EEPR_OP_RECOVER, 3'h5, 16'h0000, 8'h00);
		run(EEPR_OP_READ, 3'h5, 16'h0040, 8'h00);
		chk("rec_data", rdata, 16'h0011);
		finish_test();
	end
endmodule
